// ===== core/limit_switch_pkg.sv
// Package for the limit switch output: register map, field layouts,
// reset values, mode encodings and the delay time base.
// Assumes a 125 MHz clock and an APB master with 32-bit data.
// Functional notes
// - In diagnostic mode software chooses alarm, alarm or warning, or warning as the controlling event class.
// - In diagnostic mode the output is closed while no chosen event is active and open while one is.
// - Switch-on and switch-off thresholds are signed floating-point values in the measured variable's units.
// - With switch-on above switch-off, the output closes once the value rises above switch-on.
// - With switch-on above switch-off, the output opens once the value drops below switch-off.
// - With switch-on below switch-off, the output closes once the value falls below switch-on.
// - With switch-on below switch-off, the output opens once the value rises above switch-off.
// - In limit mode with a variable assigned, closing is postponed by a switch-on delay of 0.0 to 100.0 s.
// - In limit mode with a variable assigned, opening is postponed by a switch-off delay of 0.0 to 100.0 s.
// - In limit or digital-output mode an alarm keeps the computed state or forces open or closed.
// - The present open or closed state of the switch can be read back as a status value.
// - A yes/no polarity setting exists, and no leaves the behaviour unchanged.
// - Polarity yes swaps open and closed relative to the plain behaviour in every mode.
package limit_switch_pkg;

  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_ON_VALUE  = 8'h04;
  localparam logic [7:0]  OFF_OFF_VALUE = 8'h08;
  localparam logic [7:0]  OFF_ON_DELAY  = 8'h0C;
  localparam logic [7:0]  OFF_OFF_DELAY = 8'h10;
  localparam logic [7:0]  OFF_STATUS    = 8'h14;

  // Control field positions
  localparam int CTRL_FUNC_LSB   = 0;
  localparam int CTRL_CLASS_LSB  = 4;
  localparam int CTRL_FAIL_LSB   = 6;
  localparam int CTRL_INVERT_BIT = 8;
  localparam int CTRL_ASSIGN_BIT = 9;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [9:0]  DELAY_RESET = 10'h000;

  // Delays are kept in tenths of a second, up to 100.0 s
  localparam logic [9:0]  DELAY_MAX_STEPS = 10'h3E8;
  localparam int          DELAY_STEP_MS   = 100;
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          STEP_CYCLES     = DELAY_STEP_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    FUNC_OFF, FUNC_ON, FUNC_DIAG, FUNC_LIMIT, FUNC_DIGITAL
  } func_t;

  typedef enum logic [1:0] {
    CLASS_ALARM, CLASS_ALARM_OR_WARN, CLASS_WARN
  } diag_class_t;

  typedef enum logic [1:0] {
    FAIL_ACTUAL, FAIL_OPEN, FAIL_CLOSED
  } fail_mode_t;

  typedef struct packed {
    logic        assigned;
    logic        invert;
    fail_mode_t  fail_mode;
    diag_class_t diag_class;
    logic [0:0]  spare;
    func_t       func;
  } ctrl_t;

  typedef struct packed {
    logic        digital;
    logic        warning;
    logic        alarm;
    logic [31:0] value;
  } meas_t;

endpackage

// ===== core/limit_switch_output.sv
// Switch output controller with APB register access.
// Assumes measured value and event inputs come from logic on i_clk.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module limit_switch_output
  import limit_switch_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire meas_t       i_meas,
  output logic             o_switch_closed
);

  ctrl_t       ctrl_reg;
  logic [31:0] on_value_reg;
  logic [31:0] off_value_reg;
  logic [9:0]  on_delay_reg;
  logic [9:0]  off_delay_reg;
  logic [31:0] prdata_reg;
  logic        err_reg;
  logic        limit_reg;
  logic [9:0]  step_cnt_reg;
  logic [31:0] presc_reg;
  logic        out_reg;

  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] meas_key;
  logic [31:0] on_key;
  logic [31:0] off_key;
  logic        rising_mode;
  logic        target;
  logic        pending;
  logic [9:0]  dly_sel;
  logic        tick;
  logic        event_sel;
  logic        base_state;
  logic        forced_state;

  // Maps an IEEE single to a key whose unsigned order is numeric order
  function automatic logic [31:0] float_key(input logic [31:0] f);
    float_key = f[31] ? ~f : {1'b1, f[30:0]};
  endfunction

  function automatic logic [9:0] clamp_delay(input logic [31:0] d);
    clamp_delay = (d > {22'h0, DELAY_MAX_STEPS}) ? DELAY_MAX_STEPS
                                                 : d[9:0];
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_ON_VALUE) ||
                (a == OFF_OFF_VALUE) || (a == OFF_ON_DELAY) ||
                (a == OFF_OFF_DELAY) || (a == OFF_STATUS);
  endfunction

  // Bus decode; zero wait states, data captured in the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign mapped  = is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_reg;
  assign prdata  = prdata_reg;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL:      rd_val = {22'h0, ctrl_reg};
      OFF_ON_VALUE:  rd_val = on_value_reg;
      OFF_OFF_VALUE: rd_val = off_value_reg;
      OFF_ON_DELAY:  rd_val = {22'h0, on_delay_reg};
      OFF_OFF_DELAY: rd_val = {22'h0, off_delay_reg};
      OFF_STATUS:    rd_val = {29'h0, pending, limit_reg, out_reg};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
      err_reg    <= !mapped || (pwrite && paddr == OFF_STATUS);
    end
  end

  // thresholds stored as raw signed floats
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg      <= ctrl_t'(CTRL_RESET[9:0]);
      on_value_reg  <= VALUE_RESET;
      off_value_reg <= VALUE_RESET;
      on_delay_reg  <= DELAY_RESET;
      off_delay_reg <= DELAY_RESET;
    end else if (wr_en) begin
      unique case (paddr)
        OFF_CTRL:      ctrl_reg      <= ctrl_t'(pwdata[9:0]);
        OFF_ON_VALUE:  on_value_reg  <= pwdata;
        OFF_OFF_VALUE: off_value_reg <= pwdata;
        OFF_ON_DELAY:  on_delay_reg  <= clamp_delay(pwdata);
        OFF_OFF_DELAY: off_delay_reg <= clamp_delay(pwdata);
        default:       ;
      endcase
    end
  end

  assign meas_key    = float_key(i_meas.value);
  assign on_key      = float_key(on_value_reg);
  assign off_key     = float_key(off_value_reg);
  assign rising_mode = on_key > off_key;

  // Hysteresis comparator
  always_comb begin
    target = limit_reg;
    if (!ctrl_reg.assigned) begin
      target = 1'b0;
    end else if (rising_mode) begin
      if (meas_key > on_key) begin
        target = 1'b1;
      end else if (meas_key < off_key) begin
        target = 1'b0;
      end else begin
        target = limit_reg;
      end
    end else begin
      if (meas_key < on_key) begin
        target = 1'b1;
      end else if (meas_key > off_key) begin
        target = 1'b0;
      end else begin
        target = limit_reg;
      end
    end
  end

  // Delay runs only while the target differs; a glitch restarts it
  assign pending = target != limit_reg;
  assign dly_sel = target ? on_delay_reg : off_delay_reg;
  assign tick    = presc_reg == 32'(STEP_CYC - 1);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      presc_reg <= 32'h0000_0000;
    end else if (!pending || tick) begin
      presc_reg <= 32'h0000_0000;
    end else begin
      presc_reg <= presc_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_cnt_reg <= 10'h000;
      limit_reg    <= 1'b0;
    end else if (!pending) begin
      step_cnt_reg <= 10'h000;
    end else if (step_cnt_reg >= dly_sel) begin
      step_cnt_reg <= 10'h000;
      limit_reg    <= target;
    end else if (tick) begin
      step_cnt_reg <= step_cnt_reg + 10'h001;
    end
  end

  always_comb begin
    unique case (ctrl_reg.diag_class)
      CLASS_ALARM:         event_sel = i_meas.alarm;
      CLASS_ALARM_OR_WARN: event_sel = i_meas.alarm || i_meas.warning;
      CLASS_WARN:          event_sel = i_meas.warning;
      default:             event_sel = i_meas.alarm;
    endcase
  end

  always_comb begin
    unique case (ctrl_reg.func)
      FUNC_OFF:     base_state = 1'b0;
      FUNC_ON:      base_state = 1'b1;
      FUNC_DIAG:    base_state = !event_sel;
      FUNC_LIMIT:   base_state = limit_reg;
      FUNC_DIGITAL: base_state = i_meas.digital;
      default:      base_state = 1'b0;
    endcase
  end

  always_comb begin
    forced_state = base_state;
    if ((ctrl_reg.func == FUNC_LIMIT || ctrl_reg.func == FUNC_DIGITAL)
        && i_meas.alarm) begin
      unique case (ctrl_reg.fail_mode)
        FAIL_OPEN:   forced_state = 1'b0;
        FAIL_CLOSED: forced_state = 1'b1;
        default:     forced_state = base_state;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= forced_state ^ ctrl_reg.invert;
    end
  end

  assign o_switch_closed = out_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_diag_plain;
    ctrl_reg.func == FUNC_DIAG && !ctrl_reg.invert;
  endsequence

  sequence s_limit_steady;
    ctrl_reg.func == FUNC_LIMIT && !ctrl_reg.invert && !i_meas.alarm;
  endsequence

  property p_class_sel;
    ctrl_reg.diag_class == CLASS_WARN |-> event_sel == i_meas.warning;
  endproperty
  a_class_sel: assert property (p_class_sel)
    else $error("warning class does not follow warning input");

  property p_diag_open;
    s_diag_plain and (event_sel == 1'b1) |=> !o_switch_closed;
  endproperty
  a_diag_open: assert property (p_diag_open)
    else $error("diagnostic event did not open output");

  property p_diag_closed;
    s_diag_plain and (event_sel == 1'b0) |=> o_switch_closed;
  endproperty
  a_diag_closed: assert property (p_diag_closed)
    else $error("output not closed without a diagnostic event");

  property p_thr_store;
    wr_en && paddr == OFF_ON_VALUE |=> on_value_reg == $past(pwdata);
  endproperty
  a_thr_store: assert property (p_thr_store)
    else $error("switch-on value not stored");

  property p_rise_close;
    ctrl_reg.assigned && rising_mode && meas_key > on_key |-> target;
  endproperty
  a_rise_close: assert property (p_rise_close)
    else $error("no close above switch-on");

  property p_rise_open;
    ctrl_reg.assigned && rising_mode && meas_key < off_key |-> !target;
  endproperty
  a_rise_open: assert property (p_rise_open)
    else $error("no open below switch-off");

  property p_fall_close;
    ctrl_reg.assigned && !rising_mode && meas_key < on_key |-> target;
  endproperty
  a_fall_close: assert property (p_fall_close)
    else $error("no close below switch-on");

  property p_fall_open;
    ctrl_reg.assigned && !rising_mode && meas_key > off_key
      && meas_key >= on_key |-> !target;
  endproperty
  a_fall_open: assert property (p_fall_open)
    else $error("no open above switch-off");

  property p_band_hold;
    ctrl_reg.assigned && meas_key <= (rising_mode ? on_key : off_key)
      && meas_key >= (rising_mode ? off_key : on_key) |=> $stable(limit_reg);
  endproperty
  a_band_hold: assert property (p_band_hold)
    else $error("limit state moved without a pending change");

  property p_on_delay;
    $rose(limit_reg) |-> $past(step_cnt_reg) == $past(on_delay_reg);
  endproperty
  a_on_delay: assert property (p_on_delay)
    else $error("close not at switch-on delay");

  property p_off_delay;
    $fell(limit_reg) && $past(ctrl_reg.assigned)
      |-> $past(step_cnt_reg) == $past(off_delay_reg);
  endproperty
  a_off_delay: assert property (p_off_delay)
    else $error("open not at switch-off delay");

  property p_unassigned;
    !ctrl_reg.assigned |-> !target;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("limit target closed with no variable assigned");

  property p_fail_closed;
    ctrl_reg.func == FUNC_LIMIT && !ctrl_reg.invert && i_meas.alarm
      && ctrl_reg.fail_mode == FAIL_CLOSED |=> o_switch_closed;
  endproperty
  a_fail_closed: assert property (p_fail_closed)
    else $error("alarm did not force closed");

  property p_status_read;
    setup && !pwrite && paddr == OFF_STATUS
      |=> prdata[0] == $past(o_switch_closed);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status readback mismatch");

  property p_no_invert;
    s_limit_steady ##1 s_limit_steady |-> o_switch_closed == $past(limit_reg);
  endproperty
  a_no_invert: assert property (p_no_invert)
    else $error("plain polarity changed the output");

  property p_invert;
    ctrl_reg.func == FUNC_ON && ctrl_reg.invert |=> !o_switch_closed;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inversion did not swap state");

endmodule

// ===== verification/limit_switch_output_bench.sv
// Testbench for the switch output block: APB tasks reach the registers,
// the measured value and event inputs are driven straight from here.
// Assumes pready may be delayed; the watchdog bounds every wait.
`timescale 1ns/1ps
module limit_switch_output_bench;
  import limit_switch_pkg::*;
  // Short delay step keeps the run brief; timing derives from it
  localparam int STEP = 4;
  localparam logic [31:0] F_HALF = 32'h3F00_0000;
  localparam logic [31:0] F_TWO  = 32'h4000_0000;
  localparam logic [31:0] F_MTWO = 32'hC000_0000;
  localparam logic [31:0] F_ONE  = 32'h3F80_0000;
  localparam logic [31:0] F_MONE = 32'hBF80_0000;
  logic        i_clk;
  logic        i_rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        o_switch_closed;
  meas_t       meas;
  logic [1:0]  c;
  logic [1:0]  e;
  logic        inv;
  logic        act;
  int          fails;
  int          tests_run;

  limit_switch_output #(.STEP_CYC(STEP)) limit_switch_output_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_meas(meas),
    .o_switch_closed(o_switch_closed));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge i_clk);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] mk(input func_t f, input logic [1:0] cl,
                                     input logic [1:0] fm, input logic iv);
    ctrl_t r;
    r = '0;
    r.func = f;
    r.diag_class = diag_class_t'(cl);
    r.fail_mode = fail_mode_t'(fm);
    r.invert = iv;
    r.assigned = 1'b1;
    return {22'h0, r};
  endfunction

  task automatic ck_out(input logic exp);
    chk({31'h0, o_switch_closed}, {31'h0, exp});
  endtask

  // Drive inputs, let three edges pass, then check pin and status
  task automatic mv(input logic a, input logic w, input logic dg,
                    input logic [31:0] v, input logic exp);
    @(posedge i_clk);
    meas <= {dg, w, a, v};
    repeat (3) @(posedge i_clk);
    ck_out(exp);
    rd(OFF_STATUS);
    chk(rdata & 32'h1, {31'h0, exp});
  endtask

  // Output holds through n1 edges and has switched n2 edges later
  task automatic dly(input logic [31:0] v, input int n1, input int n2,
                     input logic exp);
    @(posedge i_clk);
    meas <= {3'b000, v};
    repeat (n1) @(posedge i_clk);
    ck_out(~exp);
    repeat (n2) @(posedge i_clk);
    ck_out(exp);
  endtask

  initial begin
    i_rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    meas = '0;
    fails = 0;
    tests_run = 0;
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(OFF_CTRL);
    chk(rdata, CTRL_RESET);
    rd(OFF_ON_VALUE);
    chk(rdata, VALUE_RESET);
    rd(OFF_OFF_DELAY);
    chk(rdata, {22'h0, DELAY_RESET});
    rd(8'h18);
    chk({rdata[30:0], err}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    wr(OFF_ON_DELAY, 32'h0000_07D0);
    rd(OFF_ON_DELAY);
    chk(rdata, {22'h0, DELAY_MAX_STEPS});
    wr(OFF_STATUS, 32'h1);
    chk({31'h0, err}, 32'h1);
    ck_out(1'b0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, mk(i[1] ? FUNC_ON : FUNC_OFF, 2'h0, 2'h0, i[0]));
      mv(1'b0, 1'b0, 1'b0, 32'h0, i[1] ^ i[0]);
    end
    $display("test fixed states done");
    for (int k = 0; k < 24; k++) begin
      c = 2'(k % 3);
      e = 2'((k / 3) % 4);
      inv = (k >= 12);
      act = (c == 2'h0) ? e[0] : (c == 2'h1) ? |e : e[1];
      wr(OFF_CTRL, mk(FUNC_DIAG, c, 2'h0, inv));
      mv(e[0], e[1], 1'b0, 32'h0, ~act ^ inv);
    end
    $display("test diagnostic done");
    wr(OFF_ON_DELAY, 32'h0);
    wr(OFF_ON_VALUE, F_ONE);
    wr(OFF_OFF_VALUE, F_MONE);
    rd(OFF_OFF_VALUE);
    chk(rdata, F_MONE);
    wr(OFF_CTRL, mk(FUNC_LIMIT, 2'h0, 2'h0, 1'b0));
    mv(1'b0, 1'b0, 1'b0, F_HALF, 1'b0);
    mv(1'b0, 1'b0, 1'b0, F_TWO, 1'b1);
    mv(1'b0, 1'b0, 1'b0, F_HALF, 1'b1);
    mv(1'b0, 1'b0, 1'b0, F_MTWO, 1'b0);
    mv(1'b0, 1'b0, 1'b0, F_HALF, 1'b0);
    wr(OFF_ON_VALUE, F_MONE);
    wr(OFF_OFF_VALUE, F_ONE);
    mv(1'b0, 1'b0, 1'b0, F_HALF, 1'b0);
    mv(1'b0, 1'b0, 1'b0, F_MTWO, 1'b1);
    mv(1'b0, 1'b0, 1'b0, F_HALF, 1'b1);
    mv(1'b0, 1'b0, 1'b0, F_TWO, 1'b0);
    $display("test limit done");
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, mk(FUNC_LIMIT, 2'h0, 2'(i % 3), 1'b0));
      act = (i % 3 == 0) ? (i >= 3) : (i % 3 == 2);
      mv(1'b1, 1'b0, 1'b0, (i >= 3) ? F_MTWO : F_TWO, act);
    end
    wr(OFF_CTRL, mk(FUNC_DIGITAL, 2'h0, 2'h1, 1'b0));
    mv(1'b0, 1'b0, 1'b1, F_TWO, 1'b1);
    mv(1'b1, 1'b0, 1'b1, F_TWO, 1'b0);
    $display("test failure mode done");
    wr(OFF_CTRL, mk(FUNC_LIMIT, 2'h0, 2'h0, 1'b0));
    mv(1'b0, 1'b0, 1'b0, F_TWO, 1'b0);
    wr(OFF_ON_DELAY, 32'h2);
    wr(OFF_OFF_DELAY, 32'h3);
    // Two steps: closes 2*STEP+2 edges on; three steps: 3*STEP+2
    dly(F_MTWO, 2 * STEP + 1, 2, 1'b1);
    dly(F_TWO, 3 * STEP + 1, 2, 1'b0);
    // No variable assigned: the limit state stays open even with no delay
    wr(OFF_ON_DELAY, 32'h0);
    wr(OFF_CTRL,
       mk(FUNC_LIMIT, 2'h0, 2'h0, 1'b0) & ~(32'h1 << CTRL_ASSIGN_BIT));
    mv(1'b0, 1'b0, 1'b0, F_MTWO, 1'b0);
    $display("test delays done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    give_verdict();
  end
endmodule
